// ---- hdl/upc_pkg.sv ----
// upc_pkg: register map, field positions, reset values and timing for the
// usb port common control block.
// assumes a cpu register port of 32-bit longword accesses at byte addresses.
package upc_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_PHY_TUNING_A       = 32'hffe70094;
    localparam logic [31:0] ADDR_PHY_TUNING_B       = 32'hffe7009c;
    localparam logic [31:0] ADDR_PIN_ROLE_SELECT    = 32'hffe70800;
    localparam logic [31:0] ADDR_PHY_POWER_CONTROL  = 32'hffe70804;
    localparam logic [31:0] ADDR_MODULE_STATE       = 32'hffe70808;
    localparam logic [31:0] ADDR_HOST_EHCI_ALIGN    = 32'hffe7080c;
    localparam logic [31:0] ADDR_HOST_OHCI_ALIGN    = 32'hffe7081c;
    localparam logic [31:0] ADDR_CLOCK_SOURCE_SEL   = 32'hffe70858;

    // pin_role_select fields
    localparam int POS_ROLE_A_SENSE_PIN_SELECT       = 9;
    localparam int POS_PORT0_OVERCURRENT_PIN_SELECT = 8;
    localparam int POS_ROLE_A_ENABLE_LEVEL           = 4;
    localparam int POS_PORT0_OVERCURRENT_POLARITY   = 3;
    localparam int POS_ROLE_A_SENSE_POLARITY         = 1;
    localparam int POS_ROLE_A                       = 0;
    localparam logic [31:0] MASK_PIN_ROLE_SELECT    = 32'h0000031b;

    // phy_power_control fields
    localparam int POS_MODULE_RESET                 = 31;
    localparam int POS_PHY_RESET_RELEASE            = 2;
    localparam int POS_PLL_ENABLE                   = 1;
    localparam int POS_PHY_ENABLE                   = 0;
    localparam logic [31:0] MASK_PHY_POWER_CONTROL  = 32'h80000007;

    // module_state fields
    localparam int POS_MODULE_ACTIVE                = 31;
    localparam int POS_PLL_STABLE                   = 30;

    // clock_source_select fields
    localparam int POS_CLOCK_SOURCE                 = 7;
    localparam logic [31:0] RST_CLOCK_SOURCE_SEL    = 32'h00000224;

    // reset values
    localparam logic [31:0] RST_PHY_TUNING_A        = 32'h00400040;
    localparam logic [31:0] RST_PHY_TUNING_B        = 32'h00000000;
    localparam logic [31:0] RST_ALIGN               = 32'h00000000;
    localparam logic [31:0] RST_ZERO                = 32'h00000000;

    // timing
    localparam int CLK_PERIOD_NS                    = 10;
    localparam int STARTUP_TIME_US                  = 1000;
    localparam int STARTUP_CYCLES = (STARTUP_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES                      = 2;

    // cpu register request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } upc_req_t;

    // answer to the cpu
    typedef struct packed {
        logic        rvalid;
        logic [31:0] rdata;
    } upc_rsp_t;

    // raw pins coming from the board
    typedef struct packed {
        logic port0_overcurrent_pin;
        logic port0_overcurrent_alt_pin;
        logic role_a_sense_pin;
        logic role_a_sense_alt_pin;
        logic pll_locked;
    } upc_pins_t;

    // conditioned signals toward the controllers and phy
    typedef struct packed {
        logic port0_overcurrent;
        logic role_a_sense;
        logic role_a_power_enable_pin;
        logic role_a_function_role;
        logic phy_enable;
        logic pll_enable;
        logic phy_reset_release;
        logic module_reset;
        logic clock_source;
        logic [31:0] ehci_align;
        logic [31:0] ohci_align;
        logic [31:0] tuning_a;
        logic [31:0] tuning_b;
    } upc_ctl_t;

endpackage : upc_pkg

// ---- hdl/upc_sync.sv ----
// upc_sync: plain two-stage synchroniser, one bit wide per lane.
// assumes inputs are asynchronous to clk; output is a level.
`timescale 1ns/10ps
`default_nettype none
module upc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // data
    input  wire logic [WIDTH-1:0] d_async,
    output var  logic [WIDTH-1:0] q_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } upc_sync_st_t;

    upc_sync_st_t st_ff;
    upc_sync_st_t nxt_st;

    // first stage feeds only the second stage
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = d_async;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_sync = st_ff.stable;
endmodule : upc_sync
`default_nettype wire

// ---- hdl/upc_startup.sv ----
// upc_startup: counts the power-up settle time before the module reads active.
// assumes clk runs from reset release; counts once, never restarts.
`timescale 1ns/10ps
`default_nettype none
module upc_startup #(
    parameter int CYCLES = upc_pkg::STARTUP_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // status
    output var  logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          done;
    } upc_start_st_t;

    upc_start_st_t st_ff;
    upc_start_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!st_ff.done) begin
            nxt_st.count = st_ff.count + CW'(1);
            nxt_st.done  = (st_ff.count + CW'(1)) == LAST;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done = st_ff.done;
endmodule : upc_startup
`default_nettype wire

// ---- hdl/upc_top.sv ----
// upc_top: common usb port control and status registers.
// assumes single-cycle longword cpu accesses; pins and pll lock asynchronous.
// What this block does
// - bit 8 picks port-0 overcurrent pin
// - function mode: bit 4 drives port-1 enable
// - bit 3 sets port-0 overcurrent polarity, only while bit 9 is set
// - bit 1 sets port-1 sense polarity, only while bit 8 is set
// - bit 0 selects host or function
// - bit 31 holds module registers reset
// - bit 0 enables the phy
// - bit 1 enables pll after phy
// - bit 2 releases phy reset last
// - active reads 0 during startup
// - pll stable bit follows pll lock while phy and pll are enabled
// - bit 7 picks crystal or external clock
// - ehci alignment register holds swap code
// - ohci alignment register holds swap code
// - bit 9 picks port-1 sense pin
// - port-1 enable pulls d+ up, starts low
`timescale 1ns/10ps
`default_nettype none
module upc_top #(
    parameter int STARTUP_CYCLES = upc_pkg::STARTUP_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // cpu register port
    input  wire upc_pkg::upc_req_t req,
    output var  upc_pkg::upc_rsp_t rsp,
    // board pins and phy status
    input  wire upc_pkg::upc_pins_t pins,
    // toward controllers and phy
    output var  upc_pkg::upc_ctl_t ctl
);
    typedef struct packed {
        logic [31:0]        pin_role;
        logic [31:0]        power;
        logic [31:0]        ehci;
        logic [31:0]        ohci;
        logic [31:0]        tune_a;
        logic [31:0]        tune_b;
        logic               clk_src;
        upc_pkg::upc_rsp_t  rsp;
        upc_pkg::upc_ctl_t  ctl;
    } upc_top_st_t;

    upc_top_st_t st_ff;
    upc_top_st_t nxt_st;

    logic [4:0] pins_sync;
    logic       started;

    upc_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .d_async (pins),
        .q_sync  (pins_sync)
    );

    upc_startup #(
        .CYCLES (STARTUP_CYCLES)
    ) u_startup (
        .clk   (clk),
        .rst_n (rst_n),
        .done  (started)
    );

    upc_pkg::upc_pins_t ps;
    assign ps = pins_sync;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
        hit = (a == r);
    endfunction : hit

    logic [31:0] state_word;
    logic        pll_ok;
    logic        active;

    always_comb begin
        pll_ok = ps.pll_locked & st_ff.power[upc_pkg::POS_PLL_ENABLE]
                 & st_ff.power[upc_pkg::POS_PHY_ENABLE];
        active = started & ~st_ff.power[upc_pkg::POS_MODULE_RESET];
        state_word = upc_pkg::RST_ZERO;
        state_word[upc_pkg::POS_MODULE_ACTIVE] = active;
        state_word[upc_pkg::POS_PLL_STABLE]    = pll_ok;
    end

    logic p0_raw;
    logic p1_raw;
    logic in_function;

    always_comb begin
        nxt_st = st_ff;
        in_function = st_ff.pin_role[upc_pkg::POS_ROLE_A];

        // register writes; reserved bits never stored
        if (req.wr) begin
            if (hit(req.addr, upc_pkg::ADDR_PIN_ROLE_SELECT)) begin
                nxt_st.pin_role = req.wdata & upc_pkg::MASK_PIN_ROLE_SELECT;
            end
            if (hit(req.addr, upc_pkg::ADDR_PHY_POWER_CONTROL)) begin
                nxt_st.power = req.wdata & upc_pkg::MASK_PHY_POWER_CONTROL;
            end
            if (hit(req.addr, upc_pkg::ADDR_HOST_EHCI_ALIGN)) begin
                nxt_st.ehci = req.wdata;
            end
            if (hit(req.addr, upc_pkg::ADDR_HOST_OHCI_ALIGN)) begin
                nxt_st.ohci = req.wdata;
            end
            if (hit(req.addr, upc_pkg::ADDR_PHY_TUNING_A)) begin
                nxt_st.tune_a = req.wdata;
            end
            if (hit(req.addr, upc_pkg::ADDR_PHY_TUNING_B)) begin
                nxt_st.tune_b = req.wdata;
            end
            if (hit(req.addr, upc_pkg::ADDR_CLOCK_SOURCE_SEL)) begin
                nxt_st.clk_src = req.wdata[upc_pkg::POS_CLOCK_SOURCE];
            end
        end

        // module reset clears all but clock select and status; reset bit kept unless power control is written
        if (st_ff.power[upc_pkg::POS_MODULE_RESET]) begin
            nxt_st.pin_role = upc_pkg::RST_ZERO;
            nxt_st.ehci     = upc_pkg::RST_ALIGN;
            nxt_st.ohci     = upc_pkg::RST_ALIGN;
            nxt_st.tune_a   = upc_pkg::RST_PHY_TUNING_A;
            nxt_st.tune_b   = upc_pkg::RST_PHY_TUNING_B;
            nxt_st.power    = upc_pkg::RST_ZERO;
            if (req.wr && hit(req.addr, upc_pkg::ADDR_PHY_POWER_CONTROL)) begin
                nxt_st.power = req.wdata & upc_pkg::MASK_PHY_POWER_CONTROL;
            end else begin
                nxt_st.power[upc_pkg::POS_MODULE_RESET] = 1'b1;
            end
        end

        // reads answer next cycle; unmapped reads return zero
        nxt_st.rsp.rvalid = req.rd;
        nxt_st.rsp.rdata  = upc_pkg::RST_ZERO;
        if (req.rd) begin
            unique case (1'b1)
                hit(req.addr, upc_pkg::ADDR_PIN_ROLE_SELECT):   nxt_st.rsp.rdata = st_ff.pin_role;
                hit(req.addr, upc_pkg::ADDR_PHY_POWER_CONTROL): nxt_st.rsp.rdata = st_ff.power;
                hit(req.addr, upc_pkg::ADDR_MODULE_STATE):      nxt_st.rsp.rdata = state_word;
                hit(req.addr, upc_pkg::ADDR_HOST_EHCI_ALIGN):   nxt_st.rsp.rdata = st_ff.ehci;
                hit(req.addr, upc_pkg::ADDR_HOST_OHCI_ALIGN):   nxt_st.rsp.rdata = st_ff.ohci;
                hit(req.addr, upc_pkg::ADDR_PHY_TUNING_A):      nxt_st.rsp.rdata = st_ff.tune_a;
                hit(req.addr, upc_pkg::ADDR_PHY_TUNING_B):      nxt_st.rsp.rdata = st_ff.tune_b;
                hit(req.addr, upc_pkg::ADDR_CLOCK_SOURCE_SEL): begin
                    nxt_st.rsp.rdata = upc_pkg::RST_CLOCK_SOURCE_SEL;
                    nxt_st.rsp.rdata[upc_pkg::POS_CLOCK_SOURCE] = st_ff.clk_src;
                end
                default: nxt_st.rsp.rdata = upc_pkg::RST_ZERO;
            endcase
        end

        // pin selection, then polarity by plain inversion
        p0_raw = st_ff.pin_role[upc_pkg::POS_PORT0_OVERCURRENT_PIN_SELECT]
                 ? ps.port0_overcurrent_alt_pin : ps.port0_overcurrent_pin;
        p1_raw = st_ff.pin_role[upc_pkg::POS_ROLE_A_SENSE_PIN_SELECT]
                 ? ps.role_a_sense_alt_pin : ps.role_a_sense_pin;
        // port-0 polarity honoured only while bit 9 is set, port-1 polarity only while bit 8 is set; otherwise low-active
        nxt_st.ctl.port0_overcurrent = p0_raw ^ ~(st_ff.pin_role[upc_pkg::POS_ROLE_A_SENSE_PIN_SELECT]
                 & st_ff.pin_role[upc_pkg::POS_PORT0_OVERCURRENT_POLARITY]);
        nxt_st.ctl.role_a_sense = p1_raw ^ ~(st_ff.pin_role[upc_pkg::POS_PORT0_OVERCURRENT_PIN_SELECT]
                 & st_ff.pin_role[upc_pkg::POS_ROLE_A_SENSE_POLARITY]);

        // host mode: enable follows power-on, held low here; function: pull-up level
        nxt_st.ctl.role_a_power_enable_pin = in_function
                 & st_ff.pin_role[upc_pkg::POS_ROLE_A_ENABLE_LEVEL];
        nxt_st.ctl.role_a_function_role = in_function;

        nxt_st.ctl.phy_enable = st_ff.power[upc_pkg::POS_PHY_ENABLE];
        // pll and release gated so a wrong order cannot start the phy
        nxt_st.ctl.pll_enable = st_ff.power[upc_pkg::POS_PLL_ENABLE]
                 & st_ff.power[upc_pkg::POS_PHY_ENABLE];
        nxt_st.ctl.phy_reset_release = st_ff.power[upc_pkg::POS_PHY_RESET_RELEASE]
                 & nxt_st.ctl.pll_enable;
        nxt_st.ctl.module_reset = st_ff.power[upc_pkg::POS_MODULE_RESET];
        nxt_st.ctl.clock_source = st_ff.clk_src;
        nxt_st.ctl.ehci_align   = st_ff.ehci;
        nxt_st.ctl.ohci_align   = st_ff.ohci;
        nxt_st.ctl.tuning_a     = st_ff.tune_a;
        nxt_st.ctl.tuning_b     = st_ff.tune_b;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff                  <= '0;
            st_ff.tune_a           <= upc_pkg::RST_PHY_TUNING_A;
            st_ff.ctl.tuning_a     <= upc_pkg::RST_PHY_TUNING_A;
            st_ff.ctl.port0_overcurrent <= 1'b1;
            st_ff.ctl.role_a_sense  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rsp = st_ff.rsp;
    assign ctl = st_ff.ctl;

    property p_role_a_enable_low_in_host;
        @(posedge clk) disable iff (!rst_n)
        !st_ff.pin_role[upc_pkg::POS_ROLE_A] |=> !ctl.role_a_power_enable_pin;
    endproperty
    a_role_a_enable_low_in_host: assert property (p_role_a_enable_low_in_host)
        else $error("role_a enable high in host mode");

    property p_role_a_enable_level;
        @(posedge clk) disable iff (!rst_n)
        st_ff.pin_role[upc_pkg::POS_ROLE_A] |=>
            ctl.role_a_power_enable_pin == $past(st_ff.pin_role[upc_pkg::POS_ROLE_A_ENABLE_LEVEL]);
    endproperty
    a_role_a_enable_level: assert property (p_role_a_enable_level)
        else $error("role_a enable does not follow level bit");

    property p_pll_needs_phy;
        @(posedge clk) disable iff (!rst_n)
        ctl.pll_enable |-> ctl.phy_enable;
    endproperty
    a_pll_needs_phy: assert property (p_pll_needs_phy)
        else $error("pll enabled without phy");

    property p_release_needs_pll;
        @(posedge clk) disable iff (!rst_n)
        ctl.phy_reset_release |-> ctl.pll_enable && ctl.phy_enable;
    endproperty
    a_release_needs_pll: assert property (p_release_needs_pll)
        else $error("phy released before pll");

    property p_inactive_at_start;
        @(posedge clk) disable iff (!rst_n)
        !started && req.rd && req.addr == upc_pkg::ADDR_MODULE_STATE
        |=> !rsp.rdata[upc_pkg::POS_MODULE_ACTIVE];
    endproperty
    a_inactive_at_start: assert property (p_inactive_at_start)
        else $error("active during startup");

    property p_module_reset_clears;
        @(posedge clk) disable iff (!rst_n)
        st_ff.power[upc_pkg::POS_MODULE_RESET] |=> st_ff.pin_role == upc_pkg::RST_ZERO;
    endproperty
    a_module_reset_clears: assert property (p_module_reset_clears)
        else $error("module reset left port settings");

    property p_role_write;
        @(posedge clk) disable iff (!rst_n)
        req.wr && req.addr == upc_pkg::ADDR_PIN_ROLE_SELECT
            && !st_ff.power[upc_pkg::POS_MODULE_RESET]
        |=> ##1 ctl.role_a_function_role == $past(req.wdata[upc_pkg::POS_ROLE_A], 2);
    endproperty
    a_role_write: assert property (p_role_write)
        else $error("role not applied two cycles after write");

    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n)
        (st_ff.pin_role & ~upc_pkg::MASK_PIN_ROLE_SELECT) == upc_pkg::RST_ZERO
        && (st_ff.power & ~upc_pkg::MASK_PHY_POWER_CONTROL) == upc_pkg::RST_ZERO;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit stored");

    property p_clock_read;
        @(posedge clk) disable iff (!rst_n)
        req.rd && req.addr == upc_pkg::ADDR_CLOCK_SOURCE_SEL
        |=> rsp.rvalid && rsp.rdata[upc_pkg::POS_CLOCK_SOURCE] == ctl.clock_source;
    endproperty
    a_clock_read: assert property (p_clock_read)
        else $error("clock source readback mismatch");

    property p_phy_enable_out;
        @(posedge clk) disable iff (!rst_n)
        st_ff.power[upc_pkg::POS_PHY_ENABLE] |=> ctl.phy_enable;
    endproperty
    a_phy_enable_out: assert property (p_phy_enable_out)
        else $error("phy enable output not driven");

    property p_module_reset_out;
        @(posedge clk) disable iff (!rst_n)
        st_ff.power[upc_pkg::POS_MODULE_RESET] |=> ctl.module_reset;
    endproperty
    a_module_reset_out: assert property (p_module_reset_out)
        else $error("module reset output not driven");

    // clock select must survive the module reset
    property p_clock_kept_in_reset;
        @(posedge clk) disable iff (!rst_n)
        st_ff.power[upc_pkg::POS_MODULE_RESET]
            && !(req.wr && req.addr == upc_pkg::ADDR_CLOCK_SOURCE_SEL)
        |=> $stable(st_ff.clk_src);
    endproperty
    a_clock_kept_in_reset: assert property (p_clock_kept_in_reset)
        else $error("clock select disturbed by module reset");

    property p_port0_dedicated;
        @(posedge clk) disable iff (!rst_n)
        !st_ff.pin_role[upc_pkg::POS_PORT0_OVERCURRENT_PIN_SELECT]
            && !st_ff.pin_role[upc_pkg::POS_ROLE_A_SENSE_PIN_SELECT]
        |=> ctl.port0_overcurrent != $past(ps.port0_overcurrent_pin);
    endproperty
    a_port0_dedicated: assert property (p_port0_dedicated)
        else $error("port0 dedicated pin not inverted");

    property p_role_a_polarity;
        @(posedge clk) disable iff (!rst_n)
        st_ff.pin_role[upc_pkg::POS_PORT0_OVERCURRENT_PIN_SELECT]
            && st_ff.pin_role[upc_pkg::POS_ROLE_A_SENSE_POLARITY]
            && !st_ff.pin_role[upc_pkg::POS_ROLE_A_SENSE_PIN_SELECT]
        |=> ctl.role_a_sense == $past(ps.role_a_sense_pin);
    endproperty
    a_role_a_polarity: assert property (p_role_a_polarity)
        else $error("role_a polarity bit not honoured");
endmodule : upc_top
`default_nettype wire

// ---- bench/upc_phy_model.sv ----
// upc_phy_model: phy pll lock and power-switch sense pins for the bench.
// assumes bench sets pin levels through lvl; lock follows the enables.
`timescale 1ns/10ps
`default_nettype none
module upc_phy_model #(
    parameter int LOCK_CYCLES = 10
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // from the block
    input  wire logic               phy_enable,
    input  wire logic               pll_enable,
    // pin levels p0, p0 alt, p1, p1 alt
    input  wire logic [3:0]         lvl,
    // toward the block
    output var  upc_pkg::upc_pins_t pins
);
    logic [7:0] lock_cnt_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_ff <= 8'h00;
        end else if (!(phy_enable && pll_enable)) begin
            lock_cnt_ff <= 8'h00;
        end else if (lock_cnt_ff != 8'(LOCK_CYCLES)) begin
            lock_cnt_ff <= lock_cnt_ff + 8'h01;
        end
    end

    // lock only after a settle time with the clock running
    assign pins = {lvl, lock_cnt_ff == 8'(LOCK_CYCLES)};
endmodule : upc_phy_model
`default_nettype wire

// ---- bench/upc_top_bench.sv ----
// upc_top_bench: register tests for the usb port common control block.
// assumes upc_top with a short startup count and the phy model beside it.
`timescale 1ns/10ps
`default_nettype none
module upc_top_bench;
    localparam int STARTUP = 20;
    localparam logic [31:0] PWR = upc_pkg::ADDR_PHY_POWER_CONTROL;
    localparam logic [31:0] MS  = upc_pkg::ADDR_MODULE_STATE;
    localparam logic [31:0] PR  = upc_pkg::ADDR_PIN_ROLE_SELECT;
    localparam logic [31:0] EH  = upc_pkg::ADDR_HOST_EHCI_ALIGN;
    localparam logic [31:0] OH  = upc_pkg::ADDR_HOST_OHCI_ALIGN;
    localparam logic [31:0] CS  = upc_pkg::ADDR_CLOCK_SOURCE_SEL;
    localparam logic [31:0] TA  = upc_pkg::ADDR_PHY_TUNING_A;
    localparam logic [31:0] TB  = upc_pkg::ADDR_PHY_TUNING_B;

    logic               clk;
    logic               rst_n;
    upc_pkg::upc_req_t  req;
    upc_pkg::upc_rsp_t  rsp;
    upc_pkg::upc_pins_t pins;
    upc_pkg::upc_ctl_t  ctl;
    logic [3:0]         lvl;
    logic [31:0]        rd_val;
    logic [31:0]        cfg;
    logic               exp0;
    logic               exp1;
    int                 n_mismatch;
    int                 checks;

    upc_top #(.STARTUP_CYCLES(STARTUP)) uut (
        .clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .pins(pins), .ctl(ctl));
    upc_phy_model phy (
        .clk(clk), .rst_n(rst_n), .phy_enable(ctl.phy_enable),
        .pll_enable(ctl.pll_enable), .lvl(lvl), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    // one idle cycle after each strobe, so no signal is set twice per step
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = d;
        wait_cyc(1);
        req.wr = 1'b0;
        wait_cyc(1);
    endtask : wr

    task automatic rd(input logic [31:0] a);
        req.rd   = 1'b1;
        req.addr = a;
        wait_cyc(1);
        req.rd = 1'b0;
        chk({31'h0, rsp.rvalid}, 32'h1);
        rd_val = rsp.rdata;
        wait_cyc(1);
    endtask : rd

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_val, exp);
    endtask : rd_chk

    task automatic pwr_chk(input logic [2:0] exp);
        wait_cyc(2);
        chk({29'h0, ctl.phy_reset_release, ctl.pll_enable, ctl.phy_enable}, {29'h0, exp});
    endtask : pwr_chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        n_mismatch = 0;
        checks     = 0;
        rst_n      = 1'b0;
        req        = '0;
        lvl        = 4'hf;
        repeat (6) @(posedge clk);
        #1;
        chk(ctl.tuning_a, upc_pkg::RST_PHY_TUNING_A);
        chk({31'h0, ctl.role_a_power_enable_pin}, 32'h0);
        rst_n = 1'b1;
        rd_chk(MS, 32'h00000000);
        rd_chk(PR, 32'h00000000);
        rd_chk(PWR, 32'h00000000);
        rd_chk(EH, 32'h00000000);
        rd_chk(OH, 32'h00000000);
        rd_chk(CS, 32'h00000224);
        rd_chk(TA, 32'h00400040);
        rd_chk(TB, 32'h00000000);
        rd_chk(32'hffe70810, 32'h00000000);
        wait_cyc(STARTUP);
        rd_chk(MS, 32'h80000000);
        $display("test done: reset values");

        // pll and release stay off while earlier enables are missing
        wr(PWR, 32'h00000006);
        pwr_chk(3'b000);
        wr(PWR, 32'h7ffffff8);
        rd_chk(PWR, 32'h00000000);
        wr(PWR, 32'h00000001);
        pwr_chk(3'b001);
        wr(PWR, 32'h00000003);
        pwr_chk(3'b011);
        rd_chk(MS, 32'h80000000);
        for (int i = 0; i < 20 && rd_val !== 32'hc0000000; i++) begin
            rd(MS);
        end
        chk(rd_val, 32'hc0000000);
        wr(PWR, 32'h00000007);
        pwr_chk(3'b111);
        $display("test done: power sequence");

        wr(TA, 32'h00ff0040);
        wr(TB, 32'h00000001);
        rd_chk(TA, 32'h00ff0040);
        rd_chk(TB, 32'h00000001);
        chk(ctl.tuning_a, 32'h00ff0040);
        chk(ctl.tuning_b, 32'h00000001);
        for (int i = 0; i < 4; i++) begin
            wr(EH, 32'(i));
            wr(OH, 32'h88000000 | 32'(i));
            rd_chk(EH, 32'(i));
            rd_chk(OH, 32'h88000000 | 32'(i));
            chk(ctl.ehci_align, 32'(i));
            chk(ctl.ohci_align, 32'h88000000 | 32'(i));
        end
        $display("test done: tuning and alignment");

        wr(CS, 32'h00000080);
        rd_chk(CS, 32'h000002a4);
        chk({31'h0, ctl.clock_source}, 32'h1);
        wr(CS, 32'hffffffff);
        rd_chk(CS, 32'h000002a4);
        $display("test done: clock source");

        wr(PR, 32'hfffffce4);
        rd_chk(PR, 32'h00000000);
        wr(PR, 32'h00000011);
        wait_cyc(2);
        chk({31'h0, ctl.role_a_function_role}, 32'h1);
        chk({31'h0, ctl.role_a_power_enable_pin}, 32'h1);
        wr(PR, 32'h00000001);
        wait_cyc(2);
        chk({31'h0, ctl.role_a_power_enable_pin}, 32'h0);
        wr(PR, 32'h00000010);
        wait_cyc(2);
        chk({31'h0, ctl.role_a_function_role}, 32'h0);
        chk({31'h0, ctl.role_a_power_enable_pin}, 32'h0);
        for (int c = 0; c < 16; c++) begin
            cfg = {22'h0, c[3], c[2], 4'h0, c[1], 1'b0, c[0], 1'b0};
            wr(PR, cfg);
            for (int p = 0; p < 16; p++) begin
                lvl = p[3:0];
                wait_cyc(4);
                exp0 = (cfg[8] ? lvl[2] : lvl[3]) ^ ~(cfg[9] & cfg[3]);
                exp1 = (cfg[9] ? lvl[0] : lvl[1]) ^ ~(cfg[8] & cfg[1]);
                chk({30'h0, ctl.port0_overcurrent, ctl.role_a_sense},
                    {30'h0, exp0, exp1});
            end
        end
        $display("test done: pin select and polarity");

        wr(EH, 32'h00000003);
        wr(PR, 32'h00000001);
        wr(PWR, 32'h80000007);
        wait_cyc(2);
        chk({31'h0, ctl.module_reset}, 32'h1);
        wr(EH, 32'h00000003);
        rd_chk(EH, 32'h00000000);
        rd_chk(PR, 32'h00000000);
        rd_chk(CS, 32'h000002a4);
        rd(MS);
        chk({31'h0, rd_val[31]}, 32'h0);
        wr(PWR, 32'h00000000);
        wait_cyc(2);
        chk({31'h0, ctl.module_reset}, 32'h0);
        rd_chk(MS, 32'h80000000);
        $display("test done: module reset");
        finish_test();
    end
endmodule : upc_top_bench
`default_nettype wire
